//--- fbrsc_cfg.svh
// Overview of operation
// RULE_01: flash pulls ready_busy_n low on erase/program, releases it when finished.
// RULE_02: ready_busy_n floats in suspend states and in deep power-down.
// RULE_03: ready_busy_n is valid always, regardless of chip and output enable.
// RULE_04: supply fault sets supply_error_bit plus program or erase error bit.
// RULE_05: reset during operation keeps busy low, then aborts into deep power-down.
// RULE_06: host treats aborted data as suspect and reissues the whole sequence.
// RULE_07: power-off or reset_powerdown_n low clears the flash status register.
// RULE_08: command_user_interface latches commands; supply, enable, engine activity leave it.
// RULE_09: command_user_interface starts in read-array mode at power-up and wake.
// RULE_10: host writes read-array after erase or program before reading the array.
// RULE_11: a command write happens only while write enable and chip enable are low.
// RULE_12: erase and program need a setup write followed by a confirm/data write.
// RULE_13: while reset_powerdown_n is low the flash ignores every other control input.
// RULE_14: host waits output delay before reads and write recovery before writes.
// RULE_15: chip enable selects one device; output enable follows the read strobe.
// RULE_16: reset_powerdown_n follows a supply_valid_flag that also toggles at reset; the code drives it from control bit 8 only, and reset holds it high.
// RULE_17: read-array command code is ff, written after the last erase/program.
// RULE_18: erase is setup 20 then confirm d0, both inside the target block.
// RULE_19: program is setup 40 or 10 then the data word at the location.
// RULE_20: read data is valid within 600 ns of reset_powerdown_n rising.
// RULE_21: status ready bit reads busy exactly while ready_busy_n is held low.
`ifndef FBRSC_CFG_SVH
`define FBRSC_CFG_SVH

// ----------------------------------------
// register map (byte offsets)
// ----------------------------------------
`define FBRSC_REG_CTRL 5'h00
`define FBRSC_REG_ADDR 5'h04
`define FBRSC_REG_WDATA 5'h08
`define FBRSC_REG_STAT 5'h0c
`define FBRSC_REG_RDATA 5'h10
`define FBRSC_CTRL_PD_BIT 8
`define FBRSC_STAT_BUSY_BIT 0
`define FBRSC_STAT_PIN_BIT 1
`define FBRSC_STAT_ABORT_BIT 2
`define FBRSC_STAT_DONE_BIT 3
`define FBRSC_STAT_FLASH_LSB 8

// ----------------------------------------
// operations started through the control register
// ----------------------------------------
`define FBRSC_OP_NONE 3'h0
`define FBRSC_OP_READ_ARRAY 3'h1
`define FBRSC_OP_ERASE 3'h2
`define FBRSC_OP_PROGRAM 3'h3
`define FBRSC_OP_READ 3'h4
`define FBRSC_OP_STATUS 3'h5
`define FBRSC_OP_CLEAR 3'h6

// ----------------------------------------
// flash command codes
// ----------------------------------------
`define FBRSC_CMD_READ_ARRAY 8'hff
`define FBRSC_CMD_ERASE_SETUP 8'h20
`define FBRSC_CMD_ERASE_CONFIRM 8'hd0
`define FBRSC_CMD_PROG_SETUP 8'h40
`define FBRSC_CMD_READ_STATUS 8'h70
`define FBRSC_CMD_CLEAR_STATUS 8'h50

// ----------------------------------------
// flash status bits
// ----------------------------------------
`define FBRSC_SR_READY_BIT 7
`define FBRSC_SR_ERASE_ERR_BIT 5
`define FBRSC_SR_PROG_ERR_BIT 4
`define FBRSC_SR_SUPPLY_ERR_BIT 3

// ----------------------------------------
// timing: times in ns, cycles derived
// ----------------------------------------
`define FBRSC_CLK_NS 20
`define FBRSC_T_WE_PULSE_NS 50
`define FBRSC_T_WE_HIGH_NS 30
`define FBRSC_T_ACCESS_NS 100
`define FBRSC_T_WE_TO_BUSY_NS 100
`define FBRSC_T_RESET_TO_OUTPUT_NS 600
`define FBRSC_T_RESET_TO_WRITE_NS 1000
`define FBRSC_CYC_UP(t) (((t) + `FBRSC_CLK_NS - 1) / `FBRSC_CLK_NS)
`define FBRSC_WE_PULSE_CYC `FBRSC_CYC_UP(`FBRSC_T_WE_PULSE_NS)
`define FBRSC_WE_HIGH_CYC `FBRSC_CYC_UP(`FBRSC_T_WE_HIGH_NS)
`define FBRSC_ACCESS_CYC `FBRSC_CYC_UP(`FBRSC_T_ACCESS_NS)
`define FBRSC_WE_TO_BUSY_CYC `FBRSC_CYC_UP(`FBRSC_T_WE_TO_BUSY_NS)
`define FBRSC_WAKE_READ_CYC `FBRSC_CYC_UP(`FBRSC_T_RESET_TO_OUTPUT_NS)
`define FBRSC_WAKE_WRITE_CYC `FBRSC_CYC_UP(`FBRSC_T_RESET_TO_WRITE_NS)

`endif

//--- fbrsc_pkg.sv
package fbrsc_pkg;

	typedef enum logic [1:0] {
		FBRSC_K_END,
		FBRSC_K_WRITE,
		FBRSC_K_READ,
		FBRSC_K_WAIT
	} fbrsc_kind_t;

	typedef struct packed {
		fbrsc_kind_t kind;
		logic [15:0] data;
	} fbrsc_step_t;

	typedef enum logic [3:0] {
		FBRSC_S_IDLE,
		FBRSC_S_FETCH,
		FBRSC_S_WR_SETUP,
		FBRSC_S_WR_PULSE,
		FBRSC_S_WR_HOLD,
		FBRSC_S_RD,
		FBRSC_S_BUSY_DLY,
		FBRSC_S_BUSY_WAIT,
		FBRSC_S_PD,
		FBRSC_S_WAKE
	} fbrsc_state_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic reset_powerdown_n;
		logic dq_oe;
		logic [18:0] addr;
		logic [15:0] dq_out;
	} fbrsc_pins_t;

endpackage

//--- fbrsc_ctrl.sv
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fbrsc_cfg.svh"

module fbrsc_ctrl (
	input wire logic clock,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output fbrsc_pkg::fbrsc_pins_t flash_pins,
	input wire logic [15:0] dq_in,
	input wire logic ready_busy_n
);

	// ----------------------------------------
	// command sequences
	// ----------------------------------------
	function automatic fbrsc_pkg::fbrsc_step_t step_of(input logic [2:0] op,
			input logic [2:0] idx, input logic [15:0] wd);
		fbrsc_pkg::fbrsc_step_t s;
		s.kind = fbrsc_pkg::FBRSC_K_END;
		s.data = 16'h0000;
		case (op)
		`FBRSC_OP_ERASE, `FBRSC_OP_PROGRAM: begin
			case (idx)
			3'h0: begin
				s.kind = fbrsc_pkg::FBRSC_K_WRITE;
				s.data = {8'h00, (op == `FBRSC_OP_ERASE) ? `FBRSC_CMD_ERASE_SETUP
					: `FBRSC_CMD_PROG_SETUP}; // RULE_18 RULE_19
			end
			3'h1: begin
				// second cycle of the two-step sequence
				s.kind = fbrsc_pkg::FBRSC_K_WRITE; // RULE_12
				s.data = (op == `FBRSC_OP_ERASE) ? {8'h00, `FBRSC_CMD_ERASE_CONFIRM} : wd;
			end
			3'h2: s.kind = fbrsc_pkg::FBRSC_K_WAIT;
			3'h3: begin
				s.kind = fbrsc_pkg::FBRSC_K_WRITE;
				s.data = {8'h00, `FBRSC_CMD_READ_STATUS};
			end
			3'h4: s.kind = fbrsc_pkg::FBRSC_K_READ;
			3'h5: begin
				s.kind = fbrsc_pkg::FBRSC_K_WRITE; // RULE_10
				s.data = {8'h00, `FBRSC_CMD_READ_ARRAY}; // RULE_17
			end
			default: s.kind = fbrsc_pkg::FBRSC_K_END;
			endcase
		end
		`FBRSC_OP_STATUS: begin
			case (idx)
			3'h0: begin
				s.kind = fbrsc_pkg::FBRSC_K_WRITE;
				s.data = {8'h00, `FBRSC_CMD_READ_STATUS};
			end
			3'h1: s.kind = fbrsc_pkg::FBRSC_K_READ;
			3'h2: begin
				s.kind = fbrsc_pkg::FBRSC_K_WRITE;
				s.data = {8'h00, `FBRSC_CMD_READ_ARRAY};
			end
			default: s.kind = fbrsc_pkg::FBRSC_K_END;
			endcase
		end
		`FBRSC_OP_READ: begin
			if (idx == 3'h0) begin
				s.kind = fbrsc_pkg::FBRSC_K_READ;
			end
		end
		`FBRSC_OP_READ_ARRAY, `FBRSC_OP_CLEAR: begin
			if (idx == 3'h0) begin
				s.kind = fbrsc_pkg::FBRSC_K_WRITE;
				s.data = {8'h00, (op == `FBRSC_OP_CLEAR) ? `FBRSC_CMD_CLEAR_STATUS
					: `FBRSC_CMD_READ_ARRAY};
			end
		end
		default: s.kind = fbrsc_pkg::FBRSC_K_END;
		endcase
		return s;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	fbrsc_pkg::fbrsc_state_t state_q, state_d;
	fbrsc_pkg::fbrsc_pins_t pins_q, pins_d;
	logic [5:0] cnt_q, cnt_d;
	logic [2:0] idx_q, idx_d;
	logic [2:0] op_q, op_d;
	logic [18:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d;
	logic [15:0] rdata_q, rdata_d;
	logic [7:0] fstat_q, fstat_d;
	logic pd_q, pd_d;
	logic abort_q, abort_d;
	logic done_q, done_d;
	logic av_wait_q, av_wait_d;
	logic [31:0] av_rdata_q, av_rdata_d;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire logic av_take = (avs_read | avs_write) & av_wait_q;
	wire logic av_wr = avs_write & ~av_wait_q;
	wire logic sel_ctrl = (avs_address == `FBRSC_REG_CTRL);
	wire logic sel_addr = (avs_address == `FBRSC_REG_ADDR);
	wire logic sel_wdata = (avs_address == `FBRSC_REG_WDATA);
	wire logic idle = (state_q == fbrsc_pkg::FBRSC_S_IDLE);
	wire logic active = ~idle & (state_q != fbrsc_pkg::FBRSC_S_PD)
		& (state_q != fbrsc_pkg::FBRSC_S_WAKE);
	wire fbrsc_pkg::fbrsc_step_t cur = step_of(op_q, idx_q, wdata_q);
	wire logic [31:0] stat_word = {16'h0000, fstat_q, 4'h0, done_q, abort_q,
		ready_busy_n, ~idle}; // RULE_03
	wire logic [31:0] rd_mux = sel_ctrl ? {23'h000000, pd_q, 5'h00, op_q}
		: sel_addr ? {13'h0000, addr_q}
		: sel_wdata ? {16'h0000, wdata_q}
		: (avs_address == `FBRSC_REG_STAT) ? stat_word
		: (avs_address == `FBRSC_REG_RDATA) ? {16'h0000, rdata_q}
		: 32'h00000000;
	wire logic start = av_wr & sel_ctrl & idle & ~pd_q
		& (avs_writedata[2:0] != `FBRSC_OP_NONE);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		pins_d = pins_q;
		cnt_d = cnt_q;
		idx_d = idx_q;
		op_d = op_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		fstat_d = fstat_q;
		pd_d = pd_q;
		abort_d = abort_q;
		done_d = done_q;
		av_wait_d = ~av_take;
		av_rdata_d = av_take ? rd_mux : av_rdata_q;
		if (av_wr & sel_ctrl) begin
			pd_d = avs_writedata[`FBRSC_CTRL_PD_BIT]; // RULE_16
		end
		if (av_wr & sel_addr & idle) begin
			addr_d = avs_writedata[18:0];
		end
		if (av_wr & sel_wdata & idle) begin
			wdata_d = avs_writedata[15:0];
		end
		if (start) begin
			op_d = avs_writedata[2:0];
			idx_d = 3'h0;
			abort_d = 1'b0;
			done_d = 1'b0;
			state_d = fbrsc_pkg::FBRSC_S_FETCH;
		end
		case (state_q)
		fbrsc_pkg::FBRSC_S_IDLE: begin
			pins_d.ce_n = 1'b1;
			pins_d.oe_n = 1'b1;
			pins_d.we_n = 1'b1;
			pins_d.dq_oe = 1'b0;
		end
		fbrsc_pkg::FBRSC_S_FETCH: begin
			pins_d.addr = addr_q;
			case (cur.kind)
			fbrsc_pkg::FBRSC_K_WRITE: begin
				pins_d.ce_n = 1'b0; // RULE_15
				pins_d.dq_out = cur.data;
				state_d = fbrsc_pkg::FBRSC_S_WR_SETUP;
			end
			fbrsc_pkg::FBRSC_K_READ: begin
				pins_d.ce_n = 1'b0;
				pins_d.oe_n = 1'b0;
				cnt_d = 6'(`FBRSC_ACCESS_CYC);
				state_d = fbrsc_pkg::FBRSC_S_RD;
			end
			fbrsc_pkg::FBRSC_K_WAIT: begin
				cnt_d = 6'(`FBRSC_WE_TO_BUSY_CYC);
				state_d = fbrsc_pkg::FBRSC_S_BUSY_DLY;
			end
			default: begin
				done_d = 1'b1;
				state_d = fbrsc_pkg::FBRSC_S_IDLE;
			end
			endcase
		end
		fbrsc_pkg::FBRSC_S_WR_SETUP: begin
			pins_d.we_n = 1'b0; // RULE_11
			pins_d.dq_oe = 1'b1;
			cnt_d = 6'(`FBRSC_WE_PULSE_CYC);
			state_d = fbrsc_pkg::FBRSC_S_WR_PULSE;
		end
		fbrsc_pkg::FBRSC_S_WR_PULSE: begin
			cnt_d = cnt_q - 6'h01;
			if (cnt_q == 6'h00) begin
				pins_d.we_n = 1'b1;
				cnt_d = 6'(`FBRSC_WE_HIGH_CYC);
				state_d = fbrsc_pkg::FBRSC_S_WR_HOLD;
			end
		end
		fbrsc_pkg::FBRSC_S_WR_HOLD: begin
			cnt_d = cnt_q - 6'h01;
			if (cnt_q == 6'h00) begin
				pins_d.ce_n = 1'b1;
				pins_d.dq_oe = 1'b0;
				idx_d = idx_q + 3'h1;
				state_d = fbrsc_pkg::FBRSC_S_FETCH;
			end
		end
		fbrsc_pkg::FBRSC_S_RD: begin
			cnt_d = cnt_q - 6'h01;
			if (cnt_q == 6'h00) begin
				pins_d.ce_n = 1'b1;
				pins_d.oe_n = 1'b1;
				if (op_q == `FBRSC_OP_READ) begin
					rdata_d = dq_in;
				end else begin
					fstat_d = dq_in[7:0]; // RULE_04 RULE_21
				end
				idx_d = idx_q + 3'h1;
				state_d = fbrsc_pkg::FBRSC_S_FETCH;
			end
		end
		fbrsc_pkg::FBRSC_S_BUSY_DLY: begin
			cnt_d = cnt_q - 6'h01;
			if (cnt_q == 6'h00) begin
				state_d = fbrsc_pkg::FBRSC_S_BUSY_WAIT;
			end
		end
		fbrsc_pkg::FBRSC_S_BUSY_WAIT: begin
			// pin is watched with chip enable high
			if (ready_busy_n) begin // RULE_01 RULE_02 RULE_03
				idx_d = idx_q + 3'h1;
				state_d = fbrsc_pkg::FBRSC_S_FETCH;
			end
		end
		fbrsc_pkg::FBRSC_S_PD: begin
			if (~pd_q) begin
				pins_d.reset_powerdown_n = 1'b1;
				cnt_d = 6'(`FBRSC_WAKE_WRITE_CYC); // RULE_14 RULE_20
				state_d = fbrsc_pkg::FBRSC_S_WAKE;
			end
		end
		fbrsc_pkg::FBRSC_S_WAKE: begin
			// flash wakes in read-array mode, no command needed
			cnt_d = cnt_q - 6'h01;
			if (cnt_q == 6'h00) begin
				state_d = fbrsc_pkg::FBRSC_S_IDLE; // RULE_09 RULE_14
			end
		end
		default: state_d = fbrsc_pkg::FBRSC_S_IDLE;
		endcase
		if (pd_q & (state_q != fbrsc_pkg::FBRSC_S_PD)) begin
			pins_d.reset_powerdown_n = 1'b0;
			pins_d.ce_n = 1'b1; // RULE_13
			pins_d.oe_n = 1'b1;
			pins_d.we_n = 1'b1;
			pins_d.dq_oe = 1'b0;
			fstat_d = 8'h00; // RULE_07
			abort_d = abort_q | active; // RULE_05 RULE_06
			state_d = fbrsc_pkg::FBRSC_S_PD;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= fbrsc_pkg::FBRSC_S_IDLE;
			pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_powerdown_n: 1'b1,
				dq_oe: 1'b0, addr: 19'h00000, dq_out: 16'h0000};
			{cnt_q, idx_q, op_q, addr_q, wdata_q, rdata_q, fstat_q} <= '0;
			{pd_q, abort_q, done_q} <= 3'h0;
			av_wait_q <= 1'b1;
			av_rdata_q <= 32'h00000000;
		end else if (clk_en) begin
			state_q <= state_d;
			pins_q <= pins_d;
			{cnt_q, idx_q, op_q, addr_q, wdata_q, rdata_q, fstat_q} <=
				{cnt_d, idx_d, op_d, addr_d, wdata_d, rdata_d, fstat_d};
			{pd_q, abort_q, done_q} <= {pd_d, abort_d, done_d};
			av_wait_q <= av_wait_d;
			av_rdata_q <= av_rdata_d;
		end
	end

	assign avs_readdata = av_rdata_q;
	assign avs_waitrequest = av_wait_q;
	assign flash_pins = pins_q;

endmodule
`default_nettype wire

//--- fbrsc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbrsc_cfg.svh"

module fbrsc_ctrl_sva (
	input wire logic clock,
	input wire logic reset,
	input wire fbrsc_pkg::fbrsc_pins_t flash_pins,
	input wire logic ready_busy_n
);
	localparam int WAKE_WR = `FBRSC_WAKE_WRITE_CYC;
	localparam int WAKE_RD = `FBRSC_WAKE_READ_CYC;
	logic [5:0] wake_q;
	logic [5:0] wake_d;
	// ----------------------------------------
	// cycles since the power-down pin was raised
	// ----------------------------------------
	assign wake_d = !flash_pins.reset_powerdown_n ? 6'h00 : (&wake_q ? wake_q : wake_q + 6'h01);
	always_ff @(posedge clock) begin
		if (reset) begin
			wake_q <= 6'h3f;
		end else begin
			wake_q <= wake_d;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	AST_WE_WITH_CE: assert property (!flash_pins.we_n |-> !flash_pins.ce_n)
		else $error("write strobe without chip enable");
	AST_PD_QUIET: assert property (!flash_pins.reset_powerdown_n |-> flash_pins.we_n && flash_pins.oe_n)
		else $error("strobe active in power-down");
	AST_WAKE_WRITE: assert property (!flash_pins.we_n |-> wake_q >= WAKE_WR)
		else $error("write too soon after wake");
	AST_WAKE_READ: assert property (!flash_pins.oe_n |-> wake_q >= WAKE_RD)
		else $error("read too soon after wake");
	AST_NO_CONTENTION: assert property (!flash_pins.oe_n |-> !flash_pins.dq_oe && !flash_pins.ce_n)
		else $error("read strobe with bus driven or unselected");
	AST_WE_PULSE: assert property ($fell(flash_pins.we_n) |-> !flash_pins.we_n [*4] ##1 flash_pins.we_n)
		else $error("write pulse length wrong");
	AST_DATA_HOLD: assert property (!flash_pins.we_n |=> $stable(flash_pins.dq_out) && $stable(flash_pins.addr))
		else $error("data or address moved around write pulse");
	AST_NO_WRITE_BUSY: assert property (!ready_busy_n |-> flash_pins.we_n)
		else $error("write while device busy");
	COV_WAKE: cover property ($rose(flash_pins.reset_powerdown_n));
	COV_BUSY: cover property ($fell(ready_busy_n));
	COV_READ: cover property ($fell(flash_pins.oe_n));
endmodule

bind fbrsc_ctrl fbrsc_ctrl_sva fbrsc_ctrl_sva_inst (.clock(clock), .reset(reset),
	.flash_pins(flash_pins), .ready_busy_n(ready_busy_n));
`default_nettype wire

//--- fbrsc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

module fbrsc_flash_model (
	input wire logic clock,
	input wire fbrsc_pkg::fbrsc_pins_t pins,
	input wire logic vpp_ok,
	input wire logic [7:0] busy_len,
	output logic [15:0] dq,
	output logic rb_low
);
	logic [15:0] mem [0:7];
	logic [7:0] sr_q = 8'h80;
	logic [7:0] busy_q = 8'h00;
	logic [2:0] hold_q = 3'h0;
	logic [1:0] pend_q = 2'h0;
	logic stat_q = 1'b0;
	logic we_q = 1'b1;
	logic ce_q = 1'b1;
	logic [15:0] d_q = 16'h0000;
	logic [18:0] a_q = 19'h0;
	logic [15:0] last_q = 16'h0000;
	logic take;
	logic rd_en;
	assign take = !we_q && pins.we_n && !ce_q;
	assign rd_en = !pins.ce_n && !pins.oe_n && pins.reset_powerdown_n;
	// a released bus toggles each clock between the last driven word and its inverse
	assign dq = rd_en ? (stat_q ? {8'h00, sr_q} : mem[pins.addr[2:0]]) : ~last_q;
	assign rb_low = (busy_q != 8'h00) || (hold_q != 3'h0);
	initial begin
		for (int i = 0; i < 8; i++) mem[i] = 16'hffff;
	end
	always @(posedge clock) begin
		last_q <= dq;
		we_q <= pins.we_n;
		ce_q <= pins.ce_n;
		d_q <= pins.dq_out;
		a_q <= pins.addr;
		if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
		if (!pins.reset_powerdown_n) begin
			if (busy_q != 8'h00) hold_q <= 3'h4;
			busy_q <= 8'h00;
			sr_q <= 8'h80;
			stat_q <= 1'b0;
			pend_q <= 2'h0;
			we_q <= 1'b1;
		end else begin
			if (busy_q == 8'h01) sr_q[7] <= 1'b1;
			if (busy_q != 8'h00) busy_q <= busy_q - 8'h01;
			if (take) begin
				pend_q <= 2'h0;
				if ((pend_q == 2'h1 && d_q[7:0] == 8'hd0) || pend_q == 2'h2) begin
					busy_q <= busy_len;
					sr_q[7] <= 1'b0;
					stat_q <= 1'b1;
					if (!vpp_ok) sr_q[5:3] <= (pend_q == 2'h1) ? 3'b101 : 3'b011;
					else if (pend_q == 2'h1) for (int i = 0; i < 8; i++) mem[i] <= 16'hffff;
					else mem[a_q[2:0]] <= d_q;
				end else begin
					case (d_q[7:0])
						8'h20: pend_q <= 2'h1;
						8'h40, 8'h10: pend_q <= 2'h2;
						8'hff: stat_q <= 1'b0;
						8'h70: stat_q <= 1'b1;
						8'h50: sr_q[5:3] <= 3'b000;
						default: ;
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbrsc_cfg.svh"
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("unexpected %s: expected %h seen %h", what, exp, got); end end

module tb;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	fbrsc_pkg::fbrsc_pins_t flash_pins;
	logic [15:0] flash_dq;
	logic [15:0] dq_in;
	logic rb_low;
	logic ready_busy_n;
	logic vpp_ok = 1'b1;
	logic [7:0] busy_len = 8'h14;
	logic [31:0] rd;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	always #10 clock = ~clock;
	// pull-up on the ready line, data bus from whichever side drives
	assign ready_busy_n = rb_low ? 1'b0 : 1'b1;
	assign dq_in = flash_pins.dq_oe ? flash_pins.dq_out : flash_dq;
	fbrsc_ctrl fbrsc_ctrl_inst (.clock(clock), .reset(reset), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .flash_pins(flash_pins), .dq_in(dq_in),
		.ready_busy_n(ready_busy_n));
	fbrsc_flash_model fbrsc_flash_model_inst (.clock(clock), .pins(flash_pins),
		.vpp_ok(vpp_ok), .busy_len(busy_len), .dq(flash_dq), .rb_low(rb_low));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		// ends when avs_waitrequest drops; the bench timeout ends a hung wait
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wait_stat(input int b, input logic v);
		int n;
		n = 0;
		do begin
			av(1'b0, `FBRSC_REG_STAT, 32'h0);
			n++;
		end while (rd[b] !== v && n < 400);
		`CHK("status poll", v, rd[b])
	endtask
	task automatic t_reset;
		av(1'b0, `FBRSC_REG_STAT, 32'h0);
		`CHK("idle status", 4'h2, rd[3:0])
		av(1'b0, 5'h14, 32'h0);
		`CHK("unmapped read", 32'h0, rd)
		// request held while the clock enable freezes the block
		clk_en <= 1'b0;
		@(posedge clock);
		avs_address <= `FBRSC_REG_STAT;
		avs_read <= 1'b1;
		repeat (4) @(posedge clock);
		`CHK("frozen waitrequest", 1'b1, avs_waitrequest)
		clk_en <= 1'b1;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		`CHK("status after freeze", 4'h2, rd[3:0])
		av(1'b1, `FBRSC_REG_CTRL, 32'h1);
		wait_stat(0, 1'b0);
		`CHK("read-array done", 1'b1, rd[3])
		$display("test reset done");
	endtask
	task automatic t_program;
		av(1'b1, `FBRSC_REG_ADDR, 32'h3);
		av(1'b1, `FBRSC_REG_WDATA, 32'h5a5a);
		av(1'b1, `FBRSC_REG_CTRL, 32'h3);
		wait_stat(0, 1'b0);
		`CHK("program status", 8'h80, rd[15:8])
		`CHK("program done", 1'b1, rd[3])
		av(1'b1, `FBRSC_REG_CTRL, 32'h4);
		wait_stat(0, 1'b0);
		av(1'b0, `FBRSC_REG_RDATA, 32'h0);
		`CHK("array word", 16'h5a5a, rd[15:0])
		$display("test program done");
	endtask
	task automatic t_fault;
		vpp_ok <= 1'b0;
		for (int o = 2; o < 4; o++) begin
			av(1'b1, `FBRSC_REG_CTRL, 32'h6);
			wait_stat(0, 1'b0);
			av(1'b1, `FBRSC_REG_CTRL, 32'(o));
			wait_stat(0, 1'b0);
			`CHK("fault status", (o == 2) ? 8'ha8 : 8'h98, rd[15:8])
		end
		vpp_ok <= 1'b1;
		$display("test fault done");
	endtask
	task automatic t_abort;
		busy_len <= 8'hc8;
		av(1'b1, `FBRSC_REG_CTRL, 32'h2);
		wait_stat(1, 1'b0);
		`CHK("busy while erasing", 1'b1, rd[0])
		av(1'b1, `FBRSC_REG_CTRL, 32'h100);
		av(1'b0, `FBRSC_REG_STAT, 32'h0);
		`CHK("aborted flag", 1'b1, rd[2])
		busy_len <= 8'h14;
		av(1'b1, `FBRSC_REG_CTRL, 32'h0);
		wait_stat(0, 1'b0);
		av(1'b1, `FBRSC_REG_CTRL, 32'h5);
		wait_stat(0, 1'b0);
		`CHK("status after wake", 8'h80, rd[15:8])
		av(1'b1, `FBRSC_REG_CTRL, 32'h2);
		wait_stat(0, 1'b0);
		av(1'b1, `FBRSC_REG_CTRL, 32'h4);
		wait_stat(0, 1'b0);
		av(1'b0, `FBRSC_REG_RDATA, 32'h0);
		`CHK("erased word", 16'hffff, rd[15:0])
		$display("test abort done");
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_program();
		t_fault();
		t_abort();
		wrap_up();
	end
endmodule
`default_nettype wire
